// ===== core/gpu_pkg.sv
package gpu_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] UPPER_PIN_CONFIG_OFS = 12'h01c;
   localparam logic [11:0] WAKE_EN_POL_OFS      = 12'h020;
   localparam logic [11:0] WAKE_STATUS_OFS      = 12'h034;
   localparam logic [11:0] WAKE_MASK_OFS        = 12'h038;
   localparam logic [11:0] RESET_CTRL_OFS       = 12'h03c;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int SEL_LSB   = 24;
   localparam int DRV_LSB   = 16;
   localparam int DIR_LSB   = 8;
   localparam int LVL_LSB   = 0;
   localparam int POL_LSB   = 16;
   localparam int WK_LSB    = 0;
   localparam int RST_LITE_BIT = 0;
   localparam int UPPER_PINS   = 8;
   localparam int ALL_PINS     = 12;
   localparam int FIRST_UPPER  = 4;

   // ----------------------------------------------------------------------
   // Built-in defaults when no stored image exists
   // ----------------------------------------------------------------------
   localparam logic [7:0]  SEL_DEFAULT = 8'hff;
   localparam logic [7:0]  DRV_DEFAULT = 8'h00;
   localparam logic [7:0]  DIR_DEFAULT = 8'h00;
   localparam logic [7:0]  LVL_DEFAULT = 8'h00;
   localparam logic [11:0] POL_DEFAULT = 12'h000;
   localparam logic [11:0] WK_DEFAULT  = 12'h000;

   // Image handed over by the non-volatile loader.
   typedef struct packed {
      logic [7:0]  sel;
      logic [7:0]  drv;
      logic [7:0]  dir;
      logic [7:0]  lvl;
      logic [15:0] pol_bytes;
      logic [15:0] wk_bytes;
   } gpu_image_t;

   // Live configuration of all fields.
   typedef struct packed {
      logic [7:0]  sel;
      logic [7:0]  drv;
      logic [7:0]  dir;
      logic [7:0]  lvl;
      logic [11:0] pol;
      logic [11:0] wk;
   } gpu_cfg_t;

endpackage : gpu_pkg

// ===== core/gpu_gpio_upper.sv
`timescale 1ns/1ps

module gpu_gpio_upper (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                bus_reset,
   input  wire logic                rst_protect,
   input  wire logic                eeprom_valid,
   input  wire logic                otp_valid,
   input  wire gpu_pkg::gpu_image_t eeprom_image,
   input  wire gpu_pkg::gpu_image_t otp_image,
   input  wire logic                image_load,
   input  wire logic [11:0]         pin_in,
   output logic      [7:0]          pin_out,
   output logic      [7:0]          pin_oe,
   output logic      [7:0]          pin_alt_sel,
   input  wire logic [3:0]          lower_sel,
   input  wire logic [3:0]          lower_dir,
   output logic      [11:0]         wake_event,
   output logic                     irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   gpu_pkg::gpu_cfg_t cfg_r;
   gpu_pkg::gpu_cfg_t image_r;
   logic [11:0]       pin_s_r;
   logic [11:0]       wake_status_r;
   logic [11:0]       wake_mask_r;
   logic [11:0]       wake_cond;
   logic [11:0]       wake_prev_r;
   logic [11:0]       all_sel;
   logic [11:0]       all_dir;
   logic              lite_req;
   logic              restore;
   logic              wr_en;
   logic              rd_en;
   logic              addr_ok;

   // Two copies of the configuration are kept.
   // The live copy drives the pins and answers
   // reads. The stored copy is the image last
   // handed over by the loader, or the defaults.
   // A soft reset copies the stored image back,
   // so software changes are lost unless the
   // protect input is high.
   //
   // Image priority is fixed: first image, then
   // second, then defaults. A load pulse with no
   // valid image puts the defaults in both copies.
   //
   // Every field sits behind reset protection.
   // While protect is high, bus and lite resets
   // leave the live copy alone; an image load or
   // a bus write can still change it.
   //
   // Pins 0 to 3 are configured elsewhere. Their
   // select and direction bits come in only so
   // that wake detection covers all twelve pins.
   //
   // Pin inputs must already be synchronous. A
   // board with raw levels needs its own
   // synchroniser: the one register here aligns
   // the sample but does not cure metastability.
   //
   // The bus never waits. A write lands at the
   // edge that ends its access phase; a read of
   // the level bits shows the pins as sampled
   // one clock before that edge.
   //
   // Status can only be cleared by reading it;
   // there is no write-one-to-clear path.
   //
   // Drive per upper pin: an alternate pin or an
   // input is released; a push-pull output drives
   // both levels; an open-drain output drives
   // only while its level bit is zero.
   //
   // Wake per pin: general-purpose mode, input,
   // wake bit set, and the sample equal to the
   // polarity bit. The match is a level.
   //
   // Offsets are byte addresses of aligned
   // words; the decode is exact.

   // Pick one stored image and put it in live form; the top four bits of each 16-bit field are dropped.
   // Only twelve wake pins exist, so the top four
   // bits of each pair of bytes are never read.
   function automatic gpu_pkg::gpu_cfg_t pick_image(
      input logic               ee_ok,
      input logic               otp_ok,
      input gpu_pkg::gpu_image_t ee,
      input gpu_pkg::gpu_image_t otp
   );
      gpu_pkg::gpu_cfg_t c;
      c.sel = gpu_pkg::SEL_DEFAULT;
      c.drv = gpu_pkg::DRV_DEFAULT;
      c.dir = gpu_pkg::DIR_DEFAULT;
      c.lvl = gpu_pkg::LVL_DEFAULT;
      c.pol = gpu_pkg::POL_DEFAULT;
      c.wk  = gpu_pkg::WK_DEFAULT;
      if (ee_ok) begin
         c.sel = ee.sel;
         c.drv = ee.drv;
         c.dir = ee.dir;
         c.lvl = ee.lvl;
         c.pol = ee.pol_bytes[11:0];
         c.wk  = ee.wk_bytes[11:0];
      end else if (otp_ok) begin
         c.sel = otp.sel;
         c.drv = otp.drv;
         c.dir = otp.dir;
         c.lvl = otp.lvl;
         c.pol = otp.pol_bytes[11:0];
         c.wk  = otp.wk_bytes[11:0];
      end
      return c;
   endfunction : pick_image

   // Offsets that this slave decodes.
   // Anything else gets the error response.
   // High address bits do not alias.
   function automatic logic known_addr(input logic [11:0] a);
      return (a == gpu_pkg::UPPER_PIN_CONFIG_OFS) ||
             (a == gpu_pkg::WAKE_EN_POL_OFS)      ||
             (a == gpu_pkg::WAKE_STATUS_OFS)      ||
             (a == gpu_pkg::WAKE_MASK_OFS)        ||
             (a == gpu_pkg::RESET_CTRL_OFS);
   endfunction : known_addr

   // ----------------------------------------------------------------------
   // Bus strobes
   // ----------------------------------------------------------------------

   // Zero wait states: every access completes in its first access cycle.
   // Registers are flops and the read mux is short.
   // Unmapped offsets error, read zero, drop writes.
   assign pready  = 1'b1;
   assign addr_ok = known_addr(paddr);
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en   = psel & penable & pwrite & addr_ok;
   assign rd_en   = psel & penable & ~pwrite & addr_ok;

   // Lite reset is a self-clearing command bit.
   // It lives one clock and reads back as zero.
   // Protect blocks it just like a bus reset.
   assign lite_req = wr_en && (paddr == gpu_pkg::RESET_CTRL_OFS) &&
                     pstrb[0] && pwdata[gpu_pkg::RST_LITE_BIT];
   // Reset protection keeps the fields when a soft reset arrives.
   // A reset seen while protect is high is
   // dropped, not held until protect falls.
   assign restore  = (bus_reset | lite_req) & ~rst_protect;

   // ----------------------------------------------------------------------
   // Image capture
   // ----------------------------------------------------------------------

   // The last loaded image is kept so later soft resets can return to it.
   // Software has no path to change it.
   // Its reset value is the defaults, so a
   // restore before any load gives the defaults.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         image_r <= '{sel: gpu_pkg::SEL_DEFAULT,
                      drv: gpu_pkg::DRV_DEFAULT,
                      dir: gpu_pkg::DIR_DEFAULT,
                      lvl: gpu_pkg::LVL_DEFAULT,
                      pol: gpu_pkg::POL_DEFAULT,
                      wk:  gpu_pkg::WK_DEFAULT};
      end else if (image_load) begin
         image_r <= pick_image(eeprom_valid, otp_valid,
                               eeprom_image, otp_image);
      end
   end

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------

   // Load from image takes priority over restore, which beats bus writes.
   // A load wins since its image is what the
   // restore would return to anyway. A write
   // that collides with either is dropped.
   // Byte strobes change one field alone.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= '{sel: gpu_pkg::SEL_DEFAULT,
                    drv: gpu_pkg::DRV_DEFAULT,
                    dir: gpu_pkg::DIR_DEFAULT,
                    lvl: gpu_pkg::LVL_DEFAULT,
                    pol: gpu_pkg::POL_DEFAULT,
                    wk:  gpu_pkg::WK_DEFAULT};
      end else if (image_load) begin
         cfg_r <= pick_image(eeprom_valid, otp_valid,
                             eeprom_image, otp_image);
      end else if (restore) begin
         cfg_r <= image_r;
      end else if (wr_en && paddr == gpu_pkg::UPPER_PIN_CONFIG_OFS) begin
         // Byte lanes map one field each.
         if (pstrb[3]) cfg_r.sel <= pwdata[31:24];
         if (pstrb[2]) cfg_r.drv <= pwdata[23:16];
         if (pstrb[1]) cfg_r.dir <= pwdata[15:8];
         if (pstrb[0]) cfg_r.lvl <= pwdata[7:0];
      end else if (wr_en && paddr == gpu_pkg::WAKE_EN_POL_OFS) begin
         // Reserved bits are not stored.
         if (pstrb[3]) cfg_r.pol[11:8] <= pwdata[27:24];
         if (pstrb[2]) cfg_r.pol[7:0]  <= pwdata[23:16];
         if (pstrb[1]) cfg_r.wk[11:8]  <= pwdata[11:8];
         if (pstrb[0]) cfg_r.wk[7:0]   <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------------

   // Open-drain pins only pull low; push-pull drives both levels.
   // The level bit always sits on pin_out; pin_oe
   // alone decides whether the pad drives it. An
   // open-drain high needs the board's pull-up.
   // Alternate pins are never driven from here.
   genvar g;
   generate
      for (g = 0; g < gpu_pkg::UPPER_PINS; g++) begin : g_pin
         always_comb begin
            pin_alt_sel[g] = cfg_r.sel[g];
            pin_out[g]     = cfg_r.lvl[g];
            if (cfg_r.sel[g] || !cfg_r.dir[g]) begin
               pin_oe[g] = 1'b0;
            end else if (cfg_r.drv[g]) begin
               pin_oe[g] = 1'b1;
            end else begin
               pin_oe[g] = ~cfg_r.lvl[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Pin sampling and wake detection
   // ----------------------------------------------------------------------

   // Pins are taken as synchronous; one register aligns them to pclk.
   // Read-back and wake share this sample, so
   // they always agree on what the pin showed.
   // It is zero after reset until the first
   // clock; input levels mean nothing before.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s_r <= 12'h000;
      end else begin
         pin_s_r <= pin_in;
      end
   end

   assign all_sel = {cfg_r.sel, lower_sel};
   assign all_dir = {cfg_r.dir, lower_dir};

   // Level-sensitive: a pin holds its wake line while the match lasts.
   // An output pin is left out: its own drive
   // could otherwise wake the device.
   always_comb begin
      for (int i = 0; i < gpu_pkg::ALL_PINS; i++) begin
         wake_cond[i] = !all_sel[i] &&
                        !all_dir[i] &&
                        cfg_r.wk[i] &&
                        (pin_s_r[i] == cfg_r.pol[i]);
      end
   end

   // Registered, so compare glitches stay inside.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_event <= 12'h000;
      end else begin
         wake_event <= wake_cond;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------------

   // Last cycle's condition shows where a match begins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_prev_r <= 12'h000;
      end else begin
         wake_prev_r <= wake_cond;
      end
   end

   // A rising wake condition sets status; a new event beats the read clear.
   // The read returns the old value, so an event
   // in the clearing cycle is kept for next time.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_status_r <= 12'h000;
      end else if (rd_en && paddr == gpu_pkg::WAKE_STATUS_OFS) begin
         wake_status_r <= wake_cond & ~wake_prev_r;
      end else begin
         wake_status_r <= wake_status_r | (wake_cond & ~wake_prev_r);
      end
   end

   // Mask bits gate only the interrupt; status
   // is recorded whatever the mask holds.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_mask_r <= 12'h000;
      end else if (wr_en && paddr == gpu_pkg::WAKE_MASK_OFS) begin
         if (pstrb[1]) wake_mask_r[11:8] <= pwdata[11:8];
         if (pstrb[0]) wake_mask_r[7:0]  <= pwdata[7:0];
      end
   end

   // Level interrupt, high until status is read.
   // Status marks only the start of a match: a
   // pin held at its level sets one bit, while
   // wake_event stays high for the whole match.
   // A polarity, enable or direction change that
   // makes a pin match at once counts as a new
   // match; clear status after it if unwanted.
   // Lower select and direction bits reach
   // wake_event on the next clock.
   assign irq = |(wake_status_r & wake_mask_r);

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------

   // Level bits read back the pin, so an input shows the outside state.
   // Only the access phase uses this mux. The
   // reset control and reserved bits read zero.
   always_comb begin
      prdata = 32'h0000_0000;
      if (paddr == gpu_pkg::UPPER_PIN_CONFIG_OFS) begin
         prdata = {cfg_r.sel, cfg_r.drv, cfg_r.dir,
                   pin_s_r[11:gpu_pkg::FIRST_UPPER]};
      end else if (paddr == gpu_pkg::WAKE_EN_POL_OFS) begin
         prdata = {4'h0, cfg_r.pol, 4'h0, cfg_r.wk};
      end else if (paddr == gpu_pkg::WAKE_STATUS_OFS) begin
         prdata = {20'h00000, wake_status_r};
      end else if (paddr == gpu_pkg::WAKE_MASK_OFS) begin
         prdata = {20'h00000, wake_mask_r};
      end
   end

endmodule : gpu_gpio_upper

// ===== sim/gpu_board_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Board parts on the pins
// ----------------------------------------------------------------------
module gpu_board_model (
   input  wire logic [7:0]  pin_out,
   input  wire logic [7:0]  pin_oe,
   input  wire logic [11:0] ext_level,
   output logic      [11:0] pin_in
);
   // A driven pin shows the block's value. A released pin, and an open-drain
   // pin letting go of a one, shows whatever the outside part holds.
   assign pin_in = {(pin_oe & pin_out) | (~pin_oe & ext_level[11:4]),
                    ext_level[3:0]};
endmodule : gpu_board_model

// ===== sim/gpu_gpio_upper_checker.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module gpu_gpio_upper_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        bus_reset,
   input wire logic        rst_protect,
   input wire logic        image_load,
   input wire logic [11:0] pin_in,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe,
   input wire logic [7:0]  pin_alt_sel,
   input wire logic [3:0]  lower_sel,
   input wire logic [3:0]  lower_dir,
   input wire logic [11:0] wake_event
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A config write counts only when no restore or image load competes.
   logic acc, wr_sel, wr_cfg;
   assign acc    = psel && penable;
   assign wr_sel = acc && pwrite && paddr == 12'h01c && !image_load
                   && !(bus_reset && !rst_protect);
   assign wr_cfg = wr_sel && pwdata[31:24] == 8'h00;
   property p_reset_defaults;
      $rose(presetn) |-> pin_alt_sel == 8'hff && pin_oe == 8'h00
                         && wake_event == 12'h000;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("reset defaults wrong");
   property p_sel_write;
      wr_sel |=> pin_alt_sel == $past(pwdata[31:24]);
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("select field not applied");
   property p_out_write;
      wr_cfg |=> pin_out == $past(pwdata[7:0]);
   endproperty
   a_out_write: assert property (p_out_write)
      else $error("pin value not applied");
   property p_oe_write;
      wr_cfg |=> pin_oe == $past(pwdata[15:8] & (pwdata[23:16] | ~pwdata[7:0]));
   endproperty
   a_oe_write: assert property (p_oe_write)
      else $error("output enable wrong");
   property p_level_read;
      acc && !pwrite && paddr == 12'h01c |-> prdata[7:0] == $past(pin_in[11:4]);
   endproperty
   a_level_read: assert property (p_level_read)
      else $error("level read not from pins");
   property p_alt_no_wake;
      (wake_event[11:4] & pin_alt_sel & $past(pin_alt_sel)
       & $past(pin_alt_sel, 2)) == 8'h00;
   endproperty
   a_alt_no_wake: assert property (p_alt_no_wake)
      else $error("alternate pin woke");
   property p_lower_no_wake;
      (wake_event[3:0] & (lower_sel | lower_dir) & $past(lower_sel | lower_dir)
       & $past(lower_sel | lower_dir, 2)) == 4'h0;
   endproperty
   a_lower_no_wake: assert property (p_lower_no_wake)
      else $error("lower pin woke while not an input");
   property p_protect_hold;
      bus_reset && rst_protect && !image_load && !(acc && pwrite)
      |=> $stable(pin_alt_sel) && $stable(pin_out) && $stable(pin_oe);
   endproperty
   a_protect_hold: assert property (p_protect_hold)
      else $error("protected fields changed");
   c_wake: cover property (wake_event != 12'h000);
   c_restore: cover property (bus_reset && !rst_protect);
   c_lvl_read: cover property (acc && !pwrite && paddr == 12'h01c);
endmodule : gpu_gpio_upper_checker

bind gpu_gpio_upper gpu_gpio_upper_checker u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .bus_reset(bus_reset),
   .rst_protect(rst_protect), .image_load(image_load), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .pin_alt_sel(pin_alt_sel),
   .lower_sel(lower_sel), .lower_dir(lower_dir), .wake_event(wake_event));

// ===== sim/testbench.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module testbench;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic               bus_reset, rst_protect, eeprom_valid, otp_valid;
   logic               image_load, irq, e;
   logic [11:0]        paddr, ext, pin_in, wake_event;
   logic [31:0]        pwdata, prdata, r, v;
   logic [3:0]         pstrb, lower_sel, lower_dir;
   logic [7:0]         pin_out, pin_oe, pin_alt_sel;
   logic [95:0]        rnd;
   gpu_pkg::gpu_image_t ee_img, otp_img, im;
   gpu_pkg::gpu_cfg_t  m, saved;
   int                 n_mismatch, checks, cyc;

   gpu_gpio_upper u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_reset(bus_reset), .rst_protect(rst_protect),
      .eeprom_valid(eeprom_valid), .otp_valid(otp_valid),
      .eeprom_image(ee_img), .otp_image(otp_img), .image_load(image_load),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_alt_sel(pin_alt_sel), .lower_sel(lower_sel),
      .lower_dir(lower_dir), .wake_event(wake_event), .irq(irq));
   gpu_board_model u_board (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext), .pin_in(pin_in));

   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // A hung handshake ends the run as a failure.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   // Holds the request until pready is high at a rising edge; data is
   // taken at that edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   // Model: enabled drivers, pin levels and wake conditions.
   function automatic logic [7:0] oe_x();
      return m.dir & (m.drv | ~m.lvl) & ~m.sel;
   endfunction : oe_x
   function automatic logic [11:0] wk_x();
      logic [11:0] w, s, d;
      s = {m.sel, lower_sel};
      d = {m.dir, lower_dir};
      for (int i = 0; i < 12; i++) w[i] = !s[i] && !d[i] && m.wk[i] && ext[i] == m.pol[i];
      return w;
   endfunction : wk_x

   task automatic chk_cfg();
      logic [7:0] lv;
      lv = ((oe_x() & m.lvl) | (~oe_x() & ext[11:4])) & ~m.sel;
      apb(1'b0, 12'h01c, 32'h0);
      chk("cfg", r & {24'hffffff, ~m.sel}, {m.sel, m.drv, m.dir, lv});
      apb(1'b0, 12'h020, 32'h0);
      chk("wake_reg", r, {4'h0, m.pol, 4'h0, m.wk});
      @(negedge pclk);
      chk("alt_sel", pin_alt_sel, m.sel);
      chk("pin_oe", pin_oe & ~m.sel, oe_x());
      chk("pin_out", pin_out & oe_x(), m.lvl & oe_x());
   endtask : chk_cfg

   task automatic pulse(input int k);
      @(posedge pclk);
      if (k == 0) image_load <= 1'b1; else bus_reset <= 1'b1;
      @(posedge pclk);
      image_load <= 1'b0; bus_reset <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : pulse

   task automatic wr_cfg(input logic [31:0] d);
      apb(1'b1, 12'h01c, d);
      {m.sel, m.drv, m.dir, m.lvl} = d;
   endtask : wr_cfg

   // Main sequence.
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; bus_reset = 1'b0;
      rst_protect = 1'b0; eeprom_valid = 1'b0; otp_valid = 1'b0;
      image_load = 1'b0; ee_img = '0; otp_img = '0; lower_sel = 4'hf;
      lower_dir = 4'h0; ext = 12'h5a3;
      m = '{8'hff, 8'h00, 8'h00, 8'h00, 12'h000, 12'h000};
      v = $urandom(32'h1237fe32);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk_cfg();
      chk("wake_rst", wake_event, 12'h000);
      $display("Test reset defaults done");
      for (int k = 0; k < 10; k++) begin
         v = $urandom();
         if (k % 2 == 0) v[31:24] = 8'h00;
         wr_cfg(v);
         v = $urandom();
         apb(1'b1, 12'h020, v);
         {m.pol, m.wk} = {v[27:16], v[11:0]};
         lower_sel <= 4'($urandom()); lower_dir <= 4'($urandom());
         ext <= 12'($urandom());
         repeat (3) @(posedge pclk);
         chk_cfg();
         chk("wake_event", wake_event, wk_x());
      end
      $display("Test random config done");
      lower_sel <= 4'h0; lower_dir <= 4'h0; ext <= 12'h000;
      apb(1'b1, 12'h020, 32'h0);
      apb(1'b1, 12'h038, 32'hfff);
      apb(1'b0, 12'h034, 32'h0);
      apb(1'b1, 12'h020, 32'h00010001);
      ext <= 12'h001;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("irq_set", irq, 1'b1);
      apb(1'b0, 12'h034, 32'h0);
      chk("status", r, 32'h1);
      @(negedge pclk);
      chk("irq_clr", irq, 1'b0);
      apb(1'b1, 12'h038, 32'h0);
      ext <= 12'h000;
      repeat (3) @(posedge pclk);
      ext <= 12'h001;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("irq_masked", irq, 1'b0);
      $display("Test interrupt done");
      apb(1'b1, 12'h100, 32'hffffffff);
      chk("err_wr", e, 1'b1);
      apb(1'b0, 12'h100, 32'h0);
      chk("err_rd", r, 32'h0);
      chk("err_rd_flag", e, 1'b1);
      m.pol = 12'h001; m.wk = 12'h001;
      chk_cfg();
      $display("Test unmapped done");
      for (int s = 0; s < 3; s++) begin
         rnd = {$urandom(), $urandom(), $urandom()};
         ee_img <= rnd[63:0]; otp_img <= ~rnd[63:0];
         eeprom_valid <= (s == 0); otp_valid <= (s == 1);
         im = (s == 0) ? rnd[63:0] : ~rnd[63:0];
         m = (s == 2) ? '{8'hff, 8'h00, 8'h00, 8'h00, 12'h000, 12'h000}
             : '{im.sel, im.drv, im.dir, im.lvl, im.pol_bytes[11:0], im.wk_bytes[11:0]};
         pulse(0);
         chk_cfg();
         saved = m;
         wr_cfg($urandom());
         rst_protect <= 1'b1;
         pulse(1);
         chk_cfg();
         rst_protect <= 1'b0;
         pulse(1);
         m = saved;
         chk_cfg();
         wr_cfg($urandom());
         apb(1'b1, 12'h03c, 32'h1);
         repeat (2) @(posedge pclk);
         m = saved;
         chk_cfg();
      end
      $display("Test image and restore done");
      final_report();
   end
endmodule : testbench
